// ===== energy_accumulator.v
// active power and active energy accumulator with apb register slave
`timescale 1ns/10ps
`include "energy_acc_regs.vh"
// Behaviour
// (RQ1) power is voltage times current sample, low-pass filtered to its dc part
// (RQ2) power is scaled by one plus signed 12-bit gain over 4096
// (RQ3) signed 16-bit offset word is added to the power result
// (RQ4) offset of 256 counts equals one waveform sample lsb
// (RQ5) sign changes of power set the sign-change flag, status bit 3
// (RQ6) direction bit clear: flag set on positive-to-negative transition
// (RQ7) direction bit set: flag set on negative-to-positive transition
// (RQ8) enabled sign-change flag raises pending interrupt until cleared
// (RQ9) no accumulation while power is below selected idle threshold
// (RQ10) below threshold sets idle-load flag; enabled flag interrupts until cleared
// (RQ11) threshold field: 00 off, 01/10/11 give 0.015, 0.0075, 0.0037 percent
// (RQ12) signed 49-bit accumulator, upper 24 bits readable as energy total
// (RQ13) one power sample is accumulated every five clock periods
// (RQ14) both mode bits clear: signed accumulation, negative power subtracts
// (RQ15) both mode bits set: positive-only mode wins
// (RQ16) positive-only mode adds positive samples and ignores negative ones
// (RQ17) magnitude mode adds the magnitude of each sample
// (RQ18) power is divided by unsigned 8-bit divider, zero meaning one
// (RQ19) reading the read-clear register returns total, then clears upper 24 bits
// (RQ20) power waveform samples delivered at 25.6, 12.8, 6.4 or 3.2 kSPS
// (RQ21) energy wraps from most positive to most negative and back
// (RQ22) flags use the same corrected power that feeds the accumulator
module energy_accumulator #(
	parameter SAMPLE_W = 24,
	parameter ACC_W = 49,
	parameter LP_SHIFT = 8
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [SAMPLE_W-1:0] voltage_sample,
	input wire [SAMPLE_W-1:0] current_sample,
	output reg [SAMPLE_W-1:0] wave_sample,
	output reg wave_strobe,
	output reg irq_pending
);

	// derived widths, sample tick, waveform periods and idle thresholds
	localparam LP_W = SAMPLE_W + `OFFSET_FRAC_BITS;
	localparam PW_W = LP_W + 2;
	localparam integer SAMPLE_LAST = `SAMPLE_CLOCKS - 1;
	localparam integer WAV_N0 = `CLK_HZ / `WAV_RATE0_HZ;
	localparam integer WAV_N1 = `CLK_HZ / `WAV_RATE1_HZ;
	localparam integer WAV_N2 = `CLK_HZ / `WAV_RATE2_HZ;
	localparam integer WAV_N3 = `CLK_HZ / `WAV_RATE3_HZ;
	localparam [2:0] TICK_LAST = SAMPLE_LAST[2:0];
	localparam [15:0] WAV_P0 = WAV_N0[15:0];
	localparam [15:0] WAV_P1 = WAV_N1[15:0];
	localparam [15:0] WAV_P2 = WAV_N2[15:0];
	localparam [15:0] WAV_P3 = WAV_N3[15:0];
	localparam [63:0] TH1 = {40'h0000000000, `FULL_SCALE} * `IDLE_PPTM_1 / `PPTM_DIV;
	localparam [63:0] TH2 = {40'h0000000000, `FULL_SCALE} * `IDLE_PPTM_2 / `PPTM_DIV;
	localparam [63:0] TH3 = {40'h0000000000, `FULL_SCALE} * `IDLE_PPTM_3 / `PPTM_DIV;
	// apb access states, one-hot
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_DONE = 2'b10;

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// magnitude of a signed power word
	function [PW_W-1:0] mag;
		input [PW_W-1:0] v;
		begin
			mag = v[PW_W-1] ? (~v + 1'b1) : v;
		end
	endfunction

	// signed divide by the divider, zero treated as one
	function [PW_W-1:0] div_power;
		input [PW_W-1:0] v;
		input [7:0] d;
		reg [8:0] dd;
		begin
			dd = (d == `RST_BYTE) ? 9'h001 : {1'b0, d};
			div_power = $signed(v) / $signed(dd);
		end
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------

	// configuration, status and datapath state
	reg [1:0] apb_state_r;
	reg [7:0] waveform_select_config_r;
	reg [7:0] idle_threshold_config_r;
	reg [7:0] accumulation_config_r;
	reg [11:0] power_gain_word_r;
	reg [15:0] power_offset_word_r;
	reg [7:0] energy_divider_r;
	reg [7:0] measure_enable_low_r;
	reg [7:0] measure_enable_high_r;
	reg sign_change_flag_r;
	reg idle_load_flag_r;
	reg [2:0] tick_cnt_r;
	reg [LP_W-1:0] lowpass_r;
	reg [PW_W-1:0] power_r;
	reg last_neg_r;
	reg power_valid_r;
	reg [ACC_W-1:0] energy_r;
	reg [15:0] wav_cnt_r;

	reg idx_ok;
	reg [31:0] rd_val;
	// bus strobes; unmapped or misaligned addresses neither write nor clear
	wire [7:0] reg_idx = paddr[9:2];
	wire apb_done = psel & penable & pready;
	wire wr_en = apb_done & pwrite & idx_ok;
	wire rd_en = apb_done & ~pwrite & idx_ok;
	wire tick = (tick_cnt_r == TICK_LAST);

	// register index decode: valid when mapped
	always @* begin
		idx_ok = 1'b1;
		rd_val = 32'h00000000;
		case (reg_idx)
			`IDX_ENERGY_TOTAL: rd_val = {8'h00, energy_r[ACC_W-1:ACC_W-24]};
			`IDX_ENERGY_TOTAL_READ_CLEAR: rd_val = {8'h00, energy_r[ACC_W-1:ACC_W-24]};
			`IDX_WAVEFORM_SELECT_CONFIG: rd_val = {24'h000000, waveform_select_config_r};
			`IDX_IDLE_THRESHOLD_CONFIG: rd_val = {24'h000000, idle_threshold_config_r};
			`IDX_ACCUMULATION_CONFIG: rd_val = {24'h000000, accumulation_config_r};
			`IDX_POWER_GAIN_WORD: rd_val = {20'h00000, power_gain_word_r};
			`IDX_POWER_OFFSET_WORD: rd_val = {16'h0000, power_offset_word_r};
			`IDX_ENERGY_DIVIDER: rd_val = {24'h000000, energy_divider_r};
			`IDX_MEASURE_ENABLE_LOW: rd_val = {24'h000000, measure_enable_low_r};
			`IDX_MEASURE_ENABLE_HIGH: rd_val = {24'h000000, measure_enable_high_r};
			`IDX_MEASURE_STATUS_LOW: rd_val = {28'h0000000, sign_change_flag_r, 2'b00,
				idle_load_flag_r};
			default: idx_ok = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
			idx_ok = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ------------------------------------------------------------------

	// access phase gets pready one cycle after penable rises
	// registered answer keeps the bus inputs off any combinational output path
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state_r <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			case (apb_state_r)
				ST_IDLE: begin
					if (psel & penable) begin
						apb_state_r <= ST_DONE;
						pready <= 1'b1;
						pslverr <= ~idx_ok;
						prdata <= (pwrite | ~idx_ok) ? 32'h00000000 : rd_val;
					end
				end
				ST_DONE: begin
					apb_state_r <= ST_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					apb_state_r <= ST_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// configuration writes take effect at the completing edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_select_config_r <= `RST_BYTE;
			idle_threshold_config_r <= `RST_BYTE;
			accumulation_config_r <= `RST_BYTE;
			power_gain_word_r <= `RST_GAIN;
			power_offset_word_r <= `RST_OFFSET;
			energy_divider_r <= `RST_BYTE;
			measure_enable_low_r <= `RST_BYTE;
			measure_enable_high_r <= `RST_BYTE;
		end else if (wr_en) begin
			case (reg_idx)
				`IDX_WAVEFORM_SELECT_CONFIG: waveform_select_config_r <= pwdata[7:0];
				`IDX_IDLE_THRESHOLD_CONFIG: idle_threshold_config_r <= pwdata[7:0];
				`IDX_ACCUMULATION_CONFIG: accumulation_config_r <= pwdata[7:0];
				`IDX_POWER_GAIN_WORD: power_gain_word_r <= pwdata[11:0]; // see RQ2
				`IDX_POWER_OFFSET_WORD: power_offset_word_r <= pwdata[15:0]; // see RQ3
				`IDX_ENERGY_DIVIDER: energy_divider_r <= pwdata[7:0];
				`IDX_MEASURE_ENABLE_LOW: measure_enable_low_r <= pwdata[7:0];
				`IDX_MEASURE_ENABLE_HIGH: measure_enable_high_r <= pwdata[7:0];
				default: energy_divider_r <= energy_divider_r;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// power path
	// ------------------------------------------------------------------

	// sample tick every five clocks
	// filter, flags and accumulator all share this one tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 3'h0;
		end else begin
			tick_cnt_r <= tick ? 3'h0 : tick_cnt_r + 3'h1; // see RQ13
		end
	end

	// multiplier, low-pass, gain and offset
	wire [2*SAMPLE_W-1:0] product = $signed(voltage_sample) * $signed(current_sample);
	wire [SAMPLE_W-1:0] product_top = product[2*SAMPLE_W-2:SAMPLE_W-1];
	wire [LP_W:0] lp_diff = $signed({product_top, 8'h00}) - $signed(lowpass_r);
	wire [LP_W:0] lp_step = $signed(lp_diff) >>> LP_SHIFT;
	wire [LP_W-1:0] lp_nxt = lowpass_r + lp_step[LP_W-1:0];
	wire [LP_W+11:0] gain_prod = $signed(lowpass_r) * $signed(power_gain_word_r);
	wire [LP_W+11:0] gain_part = $signed(gain_prod) >>> `GAIN_SHIFT;
	wire [PW_W-1:0] power_gain = $signed(lowpass_r) + $signed(gain_part[PW_W-1:0]);
	wire [PW_W-1:0] power_nxt = $signed(power_gain) + $signed(power_offset_word_r);

	// lowpass and corrected power move once per sample tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lowpass_r <= {LP_W{1'b0}};
			power_r <= {PW_W{1'b0}};
			power_valid_r <= 1'b0;
		end else if (tick) begin
			lowpass_r <= lp_nxt; // see RQ1
			power_r <= power_nxt; // see RQ2 see RQ3 see RQ4
			power_valid_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// idle detection, sign detection, status flags
	// ------------------------------------------------------------------

	// magnitude of the corrected power in waveform sample units
	wire [PW_W-1:0] power_mag = mag(power_r);
	wire [PW_W-1:0] power_mag_lsb = power_mag >> `OFFSET_FRAC_BITS;
	// code 00 leaves the threshold at zero, so nothing is ever below it
	reg [PW_W-1:0] idle_th;
	always @* begin
		case (idle_threshold_config_r[1:0])
			2'b01: idle_th = TH1[PW_W-1:0]; // see RQ11
			2'b10: idle_th = TH2[PW_W-1:0];
			2'b11: idle_th = TH3[PW_W-1:0];
			default: idle_th = {PW_W{1'b0}};
		endcase
	end
	// sign and idle events, evaluated once per sample after the first
	wire below_idle = (power_mag_lsb < idle_th); // see RQ22
	wire sample_now = tick & power_valid_r;
	wire now_neg = power_r[PW_W-1];
	wire dir_np = accumulation_config_r[`BIT_SIGN_DIRECTION];
	wire sign_event = sample_now & (now_neg != last_neg_r) &
		(dir_np ? ~now_neg : now_neg); // see RQ6 see RQ7
	wire idle_event = sample_now & below_idle; // see RQ10
	wire clr_status = wr_en & (reg_idx == `IDX_MEASURE_STATUS_LOW);

	// flags are write-one-to-clear; a new event wins over the clear
	// previous sign starts positive, so a first negative sample counts as a change
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_neg_r <= 1'b0;
			sign_change_flag_r <= 1'b0;
			idle_load_flag_r <= 1'b0;
			irq_pending <= 1'b0;
		end else begin
			if (sample_now) begin
				last_neg_r <= now_neg;
			end
			if (sign_event) begin
				sign_change_flag_r <= 1'b1; // see RQ5
			end else if (clr_status & pwdata[`BIT_SIGN_CHANGE_FLAG]) begin
				sign_change_flag_r <= 1'b0;
			end
			if (idle_event) begin
				idle_load_flag_r <= 1'b1;
			end else if (clr_status & pwdata[`BIT_IDLE_LOAD_FLAG]) begin
				idle_load_flag_r <= 1'b0;
			end
			irq_pending <= (sign_change_flag_r & measure_enable_low_r[`BIT_SIGN_CHANGE_FLAG]) |
				(idle_load_flag_r & measure_enable_low_r[`BIT_IDLE_LOAD_FLAG]); // see RQ8 see RQ10
		end
	end

	// ------------------------------------------------------------------
	// energy accumulation
	// ------------------------------------------------------------------

	// divided power and mode bits; division truncates toward zero
	wire [PW_W-1:0] quotient = div_power(power_r, energy_divider_r); // see RQ18
	wire pos_only = accumulation_config_r[`BIT_POSITIVE_ONLY_SELECT];
	wire abs_mode = accumulation_config_r[`BIT_MAGNITUDE_ACCUM_SELECT];
	wire idle_block = below_idle & (idle_threshold_config_r[1:0] != 2'b00);
	// positive-only is tested before magnitude, so it wins when both are set
	reg [PW_W-1:0] acc_add;
	always @* begin
		if (idle_block) begin
			acc_add = {PW_W{1'b0}}; // see RQ9
		end else if (pos_only) begin
			acc_add = quotient[PW_W-1] ? {PW_W{1'b0}} : quotient; // see RQ15 see RQ16
		end else if (abs_mode) begin
			acc_add = mag(quotient); // see RQ17
		end else begin
			acc_add = quotient; // see RQ14
		end
	end
	// read-clear drops the upper 24 bits; the same edge's addend still lands
	wire rd_clear = rd_en & (reg_idx == `IDX_ENERGY_TOTAL_READ_CLEAR);
	wire [ACC_W-1:0] acc_base = rd_clear ? {24'h000000, energy_r[ACC_W-25:0]} : energy_r;
	wire [ACC_W-1:0] acc_ext = {{(ACC_W-PW_W){acc_add[PW_W-1]}}, acc_add};

	// wraps modulo 2^49 in both directions
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_r <= {ACC_W{1'b0}};
		end else begin
			energy_r <= acc_base + (sample_now ? acc_ext : {ACC_W{1'b0}}); // see RQ12 see RQ19 see RQ21
		end
	end

	// ------------------------------------------------------------------
	// waveform sampling of active power
	// ------------------------------------------------------------------

	// waveform sample period in clocks for the selected rate
	reg [15:0] wav_period;
	always @* begin
		case (waveform_select_config_r[`WAV_RATE_MSB:`WAV_RATE_LSB])
			2'b00: wav_period = WAV_P0;
			2'b01: wav_period = WAV_P1;
			2'b10: wav_period = WAV_P2;
			default: wav_period = WAV_P3;
		endcase
	end
	// sampling runs only when enabled with power as the source
	wire wav_on = measure_enable_high_r[`BIT_WAVEFORM_SAMPLE_ENABLE] &
		(waveform_select_config_r[`WAV_SOURCE_MSB:`WAV_SOURCE_LSB] == `WAV_SOURCE_POWER);
	wire wav_fire = wav_on & (wav_cnt_r >= wav_period - 16'h0001);

	// a counter already past a shorter new period fires at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wav_cnt_r <= 16'h0000;
			wave_sample <= {SAMPLE_W{1'b0}};
			wave_strobe <= 1'b0;
		end else begin
			wave_strobe <= wav_fire; // see RQ20
			if (!wav_on || wav_fire) begin
				wav_cnt_r <= 16'h0000;
			end else begin
				wav_cnt_r <= wav_cnt_r + 16'h0001;
			end
			if (wav_fire) begin
				wave_sample <= power_r[SAMPLE_W+`OFFSET_FRAC_BITS-1:`OFFSET_FRAC_BITS]; // see RQ4
			end
		end
	end

endmodule // energy_accumulator

// ===== energy_acc_regs.vh
// register map, field positions, reset values and timing constants of the energy accumulator
`ifndef ENERGY_ACC_REGS_VH
`define ENERGY_ACC_REGS_VH

// register indices; byte address is four times the index
`define IDX_ENERGY_TOTAL 8'h01
`define IDX_ENERGY_TOTAL_READ_CLEAR 8'h02
`define IDX_WAVEFORM_SELECT_CONFIG 8'h0D
`define IDX_IDLE_THRESHOLD_CONFIG 8'h0E
`define IDX_ACCUMULATION_CONFIG 8'h0F
`define IDX_POWER_GAIN_WORD 8'h1D
`define IDX_POWER_OFFSET_WORD 8'h20
`define IDX_ENERGY_DIVIDER 8'h24
`define IDX_MEASURE_ENABLE_LOW 8'hD9
`define IDX_MEASURE_ENABLE_HIGH 8'hDB
`define IDX_MEASURE_STATUS_LOW 8'hDC

// field positions
`define BIT_MAGNITUDE_ACCUM_SELECT 0
`define BIT_POSITIVE_ONLY_SELECT 1
`define BIT_SIGN_DIRECTION 4
`define BIT_IDLE_LOAD_FLAG 0
`define BIT_SIGN_CHANGE_FLAG 3
`define BIT_WAVEFORM_SAMPLE_ENABLE 5
`define WAV_SOURCE_LSB 0
`define WAV_SOURCE_MSB 2
`define WAV_RATE_LSB 3
`define WAV_RATE_MSB 4
`define WAV_SOURCE_POWER 3'h0

// reset values
`define RST_BYTE 8'h00
`define RST_GAIN 12'h000
`define RST_OFFSET 16'h0000

// timing: one accumulation sample every five clock periods
`define CLK_HZ 10000000
`define SAMPLE_CLOCKS 5
`define WAV_RATE0_HZ 25600
`define WAV_RATE1_HZ 12800
`define WAV_RATE2_HZ 6400
`define WAV_RATE3_HZ 3200

// gain and offset scaling
`define GAIN_SHIFT 12
`define OFFSET_FRAC_BITS 8

// idle thresholds as parts per ten million of multiplier full scale
`define FULL_SCALE 24'h7FFFFF
`define IDLE_PPTM_1 1500
`define IDLE_PPTM_2 750
`define IDLE_PPTM_3 370
`define PPTM_DIV 10000000

`endif

// ===== sample_source.sv
// sample source model driving the voltage and current channel inputs
`timescale 1ns/10ps
module sample_source (
	input wire pclk,
	input wire presetn,
	input wire [1:0] mode,
	output logic [23:0] voltage_sample,
	output logic [23:0] current_sample
);
	// mode 0 silent, 1 in phase (positive power), 2 anti phase (negative power),
	// 3 small in-phase load, between the 10 and 01 idle thresholds
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_sample <= 24'h000000;
			current_sample <= 24'h000000;
		end else begin
			voltage_sample <= (mode == 2'h0) ? 24'h000000 : (mode == 2'h1) ? 24'h400000 :
				(mode == 2'h2) ? 24'hC00000 : 24'h000900;
			current_sample <= (mode == 2'h0) ? 24'h000000 : 24'h400000;
		end
	end
endmodule // sample_source

// ===== energy_accumulator_properties.sv
// port level assertions of the energy accumulator
`timescale 1ns/10ps
module energy_accumulator_properties #(
	parameter SAMPLE_W = 24
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [SAMPLE_W-1:0] voltage_sample,
	input wire [SAMPLE_W-1:0] current_sample,
	input wire [SAMPLE_W-1:0] wave_sample,
	input wire wave_strobe,
	input wire irq_pending
);
	reg [11:0] gap_r;
	reg seen_r;
	// cycles since the last waveform strobe, saturating
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= 12'h000;
			seen_r <= 1'b0;
		end else if (wave_strobe) begin
			gap_r <= 12'h000;
			seen_r <= 1'b1;
		end else if (gap_r != 12'hFFF) begin
			gap_r <= gap_r + 12'h001;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// bus and output timing
	// ----------------------------------------
	chk_ready_one: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	chk_wait_state: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait state");
	chk_setup_quiet: assert property (psel && !penable |-> !pready) else $error("pready in setup");
	chk_idle_quiet: assert property (!psel |-> !pready && !pslverr) else $error("answer while idle");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on a write");
	chk_strobe_one: assert property (wave_strobe |=> !wave_strobe) else $error("strobe too long");
	chk_strobe_gap: assert property (wave_strobe && seen_r |-> gap_r >= 12'd389)
		else $error("waveform samples too close");
	chk_reset_quiet: assert property ($rose(presetn) |-> !irq_pending && !wave_strobe)
		else $error("output active right after reset");
	cov_error: cover property (pslverr);
	cov_strobe: cover property (wave_strobe);
	cov_irq: cover property ($rose(irq_pending));
endmodule // energy_accumulator_properties
bind energy_accumulator energy_accumulator_properties #(.SAMPLE_W(SAMPLE_W)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.voltage_sample(voltage_sample), .current_sample(current_sample),
	.wave_sample(wave_sample), .wave_strobe(wave_strobe), .irq_pending(irq_pending)
);

// ===== test_active_power_energy_accumulator.sv
// self-checking testbench of the energy accumulator
`timescale 1ns/10ps
`include "energy_acc_regs.vh"
module test_active_power_energy_accumulator;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, wave_strobe, irq_pending;
	logic [23:0] vs, cs, wave_sample, t0;
	logic [1:0] src = 2'h0;
	int fails = 0;
	int checked = 0;
	// clock of 100 ns period
	always #50 pclk = ~pclk;
	sample_source u_src (.pclk(pclk), .presetn(presetn), .mode(src), .voltage_sample(vs),
		.current_sample(cs));
	energy_accumulator #(.LP_SHIFT(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .voltage_sample(vs), .current_sample(cs),
		.wave_sample(wave_sample), .wave_strobe(wave_strobe), .irq_pending(irq_pending));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task finish_test;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task ok(input bit good, input string m);
		checked++;
		if (!good) begin
			fails++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// one apb transfer; pready, read data and error taken at the same rising edge
	task apb(input bit w, input [7:0] idx, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// energy change over about a hundred samples
	task meas(input int lo, input int hi);
		logic signed [23:0] d;
		apb(0, `IDX_ENERGY_TOTAL, 0);
		t0 = rd[23:0];
		repeat (500) @(posedge pclk);
		apb(0, `IDX_ENERGY_TOTAL, 0);
		d = rd[23:0] - t0;
		ok(d >= lo && d <= hi, "energy change out of range");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		logic [7:0] idx[11] = '{8'h01, 8'h02, 8'h0D, 8'h0E, 8'h0F, 8'h1D, 8'h20, 8'h24, 8'hD9,
			8'hDB, 8'hDC};
		foreach (idx[k]) begin
			apb(0, idx[k], 0);
			ok(rd === 32'h0 && er === 1'b0, "register not zero after reset");
		end
		apb(0, 8'h03, 0);
		ok(er === 1'b1, "unmapped read accepted");
		apb(1, `IDX_POWER_GAIN_WORD, 32'hFFFFFFFF);
		apb(0, `IDX_POWER_GAIN_WORD, 0);
		ok(rd === 32'h00000FFF, "gain width");
		apb(1, `IDX_POWER_OFFSET_WORD, 32'hFFFFFFFF);
		apb(0, `IDX_POWER_OFFSET_WORD, 0);
		ok(rd === 32'h0000FFFF, "offset width");
		apb(1, `IDX_ENERGY_DIVIDER, 32'hFFFFFFFF);
		apb(0, `IDX_ENERGY_DIVIDER, 0);
		ok(rd === 32'h000000FF, "divider width");
		apb(1, `IDX_ENERGY_TOTAL, 32'h00ABCDEF);
		apb(0, `IDX_ENERGY_TOTAL, 0);
		ok(rd === 32'h0, "energy total writable");
		apb(1, `IDX_POWER_GAIN_WORD, 0);
		apb(1, `IDX_POWER_OFFSET_WORD, 0);
		apb(1, `IDX_ENERGY_DIVIDER, 0);
	endtask
	task t_rate;
		src <= 2'h1;
		repeat (300) @(posedge pclk);
		meas(1560, 1680);
		apb(1, `IDX_ENERGY_DIVIDER, 16);
		meas(90, 110);
		apb(1, `IDX_ENERGY_DIVIDER, 0);
		apb(1, `IDX_POWER_GAIN_WORD, 32'h800);
		repeat (100) @(posedge pclk);
		meas(770, 850);
		apb(1, `IDX_POWER_GAIN_WORD, 0);
	endtask
	task t_modes;
		logic [7:0] cfg[4] = '{8'h00, 8'h02, 8'h03, 8'h01};
		int lo[4] = '{-1680, 0, 0, 1560};
		int hi[4] = '{-1560, 0, 0, 1680};
		src <= 2'h2;
		repeat (300) @(posedge pclk);
		foreach (cfg[k]) begin
			apb(1, `IDX_ACCUMULATION_CONFIG, cfg[k]);
			meas(lo[k], hi[k]);
		end
		apb(1, `IDX_ACCUMULATION_CONFIG, 0);
	endtask
	task t_sign;
		apb(1, `IDX_MEASURE_ENABLE_LOW, 32'h08);
		src <= 2'h1;
		repeat (300) @(posedge pclk);
		apb(1, `IDX_MEASURE_STATUS_LOW, 32'h09);
		src <= 2'h2;
		repeat (300) @(posedge pclk);
		apb(0, `IDX_MEASURE_STATUS_LOW, 0);
		ok(rd[3] === 1'b1 && irq_pending === 1'b1, "falling sign missed");
		apb(1, `IDX_MEASURE_STATUS_LOW, 32'h08);
		repeat (3) @(posedge pclk);
		ok(irq_pending === 1'b0, "interrupt held after clear");
		apb(1, `IDX_ACCUMULATION_CONFIG, 32'h10);
		src <= 2'h1;
		repeat (300) @(posedge pclk);
		apb(0, `IDX_MEASURE_STATUS_LOW, 0);
		ok(rd[3] === 1'b1, "rising sign missed");
		apb(1, `IDX_MEASURE_STATUS_LOW, 32'h08);
		src <= 2'h2;
		repeat (300) @(posedge pclk);
		apb(0, `IDX_MEASURE_STATUS_LOW, 0);
		ok(rd[3] === 1'b0, "falling sign flagged in rising mode");
		apb(1, `IDX_ACCUMULATION_CONFIG, 0);
		apb(1, `IDX_MEASURE_ENABLE_LOW, 0);
	endtask
	task t_idle;
		src <= 2'h1;
		repeat (300) @(posedge pclk);
		src <= 2'h0;
		repeat (300) @(posedge pclk);
		apb(1, `IDX_MEASURE_ENABLE_LOW, 32'h01);
		for (int m = 1; m < 4; m++) begin
			apb(1, `IDX_IDLE_THRESHOLD_CONFIG, m);
			apb(1, `IDX_MEASURE_STATUS_LOW, 32'h01);
			repeat (20) @(posedge pclk);
			apb(0, `IDX_MEASURE_STATUS_LOW, 0);
			ok(rd[0] === 1'b1 && irq_pending === 1'b1, "idle flag missing");
		end
		src <= 2'h3;
		apb(1, `IDX_IDLE_THRESHOLD_CONFIG, 2);
		repeat (300) @(posedge pclk);
		apb(1, `IDX_MEASURE_STATUS_LOW, 32'h01);
		repeat (20) @(posedge pclk);
		apb(0, `IDX_MEASURE_STATUS_LOW, 0);
		ok(rd[0] === 1'b0, "idle flag above the selected threshold");
		apb(1, `IDX_IDLE_THRESHOLD_CONFIG, 1);
		repeat (20) @(posedge pclk);
		apb(0, `IDX_ENERGY_TOTAL, 0);
		t0 = rd[23:0];
		repeat (1200) @(posedge pclk);
		apb(0, `IDX_ENERGY_TOTAL_READ_CLEAR, 0);
		ok(rd[23:0] === t0 && t0 !== 24'h0, "energy moved while idle");
		apb(0, `IDX_ENERGY_TOTAL, 0);
		ok(rd === 32'h0, "read clear left energy");
		apb(1, `IDX_IDLE_THRESHOLD_CONFIG, 0);
		apb(1, `IDX_MEASURE_STATUS_LOW, 32'h01);
		repeat (20) @(posedge pclk);
		ok(irq_pending === 1'b0, "idle interrupt after clear and disable");
		apb(1, `IDX_MEASURE_ENABLE_LOW, 0);
		src <= 2'h0;
	endtask
	task t_wave;
		int per[4] = '{390, 781, 1562, 3125};
		int n;
		apb(1, `IDX_POWER_OFFSET_WORD, 32'h0100);
		apb(1, `IDX_MEASURE_ENABLE_HIGH, 32'h20);
		foreach (per[r]) begin
			apb(1, `IDX_WAVEFORM_SELECT_CONFIG, r << 3);
			repeat (2) do @(negedge pclk); while (wave_strobe !== 1'b1);
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (wave_strobe !== 1'b1);
			ok(n == per[r], "waveform rate");
			ok(wave_sample === 24'h000001, "offset of 256 is not one sample lsb");
		end
		apb(1, `IDX_POWER_OFFSET_WORD, 32'hFF00);
		repeat (2) do @(negedge pclk); while (wave_strobe !== 1'b1);
		ok(wave_sample === 24'hFFFFFF, "negative offset");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_rate();
		t_modes();
		t_sign();
		t_idle();
		t_wave();
		finish_test();
	end
	initial begin
		#9000000;
		fails++;
		finish_test();
	end
endmodule // test_active_power_energy_accumulator
